// ==== eccp_dead.sv ====
`timescale 1ns/1ps
// delays the rising edge of one drive level by a programmable count
module eccp_dead #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in, delay, level out
  input wire logic lvl,
  input wire logic [W-1:0] delay,
  output logic dly_lvl
);
  logic [W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  // count down while the level is high, release when done
  always_comb
  begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (!lvl)
      cnt_d = delay;
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    else
      out_d = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dly_lvl = out_q;

  // the output never rises while the input is low
  dead_low_a: assert property (@(posedge clk) disable iff (rst)
    !lvl |=> !dly_lvl) else $error("dead band output high after low input");
endmodule

// ==== eccp_far.sv ====
`timescale 1ns/1ps
// far side: free running time base and a square capture signal
module eccp_far (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control from bench
  input wire logic cap_run,
  // toward the unit
  output logic [15:0] timer,
  output logic cap_in
);
  // edges land on a fixed timer phase, every 16 counts alternately
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer <= 16'h0000;
      cap_in <= 1'b0;
    end
    else
    begin
      timer <= timer + 16'h0001;
      cap_in <= cap_run & timer[4];
    end
  end
endmodule

// ==== eccp_map.svh ====
`ifndef ECCP_MAP_SVH
`define ECCP_MAP_SVH
// register offsets on the plain port
`define ECCP_ADDR_W 4
`define ECCP_OFF_CTRL 4'h0
`define ECCP_OFF_VAL_LO 4'h1
`define ECCP_OFF_VAL_HI 4'h2
`define ECCP_OFF_DUTY 4'h3
`define ECCP_OFF_STAT 4'h4
`define ECCP_OFF_MASK 4'h5
`define ECCP_OFF_DEAD 4'h6
`define ECCP_OFF_SHUT 4'h7
`define ECCP_OFF_PERIOD 4'h8
// control register fields
`define ECCP_CTRL_RESET 8'h00
`define ECCP_MODE_OFF 4'h0
`define ECCP_MODE_TOGGLE 4'h2
`define ECCP_MODE_CAP_FALL 4'h4
`define ECCP_MODE_CAP_RISE 4'h5
`define ECCP_MODE_CAP_4TH 4'h6
`define ECCP_MODE_CAP_16TH 4'h7
`define ECCP_MODE_CMP_SET 4'h8
`define ECCP_MODE_CMP_CLR 4'h9
`define ECCP_MODE_CMP_SW 4'ha
`define ECCP_MODE_CMP_TRIG 4'hb
`define ECCP_CFG_SINGLE 2'h0
`define ECCP_CFG_FWD 2'h1
`define ECCP_CFG_HALF 2'h2
`define ECCP_CFG_REV 2'h3
// status bits
`define ECCP_ST_MATCH 0
`define ECCP_ST_FAULT 1
`endif

// ==== eccp_pkg.sv ====
package eccp_pkg;
  typedef struct packed {
    logic [1:0] bridge_output_config;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } eccp_ctrl_t;
  typedef struct packed {
    logic pwm_out_a;
    logic pwm_out_b;
    logic pwm_out_c;
    logic pwm_out_d;
  } eccp_outs_t;
  typedef enum logic [1:0] {
    ECCP_RUN,
    ECCP_SHUT
  } eccp_state_t;
endpackage

// ==== eccp_unit.sv ====
`timescale 1ns/1ps
`include "eccp_map.svh"
// Function
// - 16-bit value register is capture or compare register by mode.
// - mode 0000 turns unit off and resets its internal state.
// - mode 0010 toggles output A on every timer match.
// - mode 0100 captures on falling edge, 0101 on rising edge.
// - mode 0110 captures once per four rising edges.
// - mode 1111 makes all four PWM outputs active low.
// - capture and compare modes use only output A, B-D return to port.
// - config 11 in PWM: B modulated, C active, A and D inactive.
// - PWM duty is 10 bits: duty byte high, control low bits.
// - two or four outputs, steering, polarity and dead band supported.
// - in PWM modes outputs shut down on fault and restart at period end after it clears, only if auto restart is set.
module eccp_unit #(
  parameter int DEAD_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`ECCP_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // time base and capture input
  input wire logic [15:0] timer,
  input wire logic cap_in,
  input wire logic fault,
  // outputs and pin ownership
  output eccp_pkg::eccp_outs_t pwm_out,
  output eccp_pkg::eccp_outs_t pwm_oe,
  output logic adc_trigger,
  output logic irq
);
  eccp_pkg::eccp_ctrl_t ctrl_q, ctrl_d;
  logic [15:0] val_q, val_d;
  logic [7:0] duty_q, duty_d, period_q, period_d, dead_q, dead_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic shut_auto_q, shut_auto_d;
  eccp_pkg::eccp_state_t st_q, st_d;
  logic [7:0] rdata_q, rdata_d;
  logic cap_q, cap_d, pin_q, pin_d, trig_q, trig_d;
  logic [3:0] pre_q, pre_d;
  logic [9:0] pcnt_q, pcnt_d;
  logic [3:0] mode;
  logic fall, rise, match, cap_ev, pwm_mode, mod, mod_n_raw;
  logic dly_p, dly_n;
  eccp_pkg::eccp_outs_t act, lvl, oe;

  assign mode = ctrl_q.unit_mode_select;
  assign pwm_mode = (mode[3:2] == 2'b11);
  assign fall = cap_q && !cap_in;
  assign rise = !cap_q && cap_in;
  assign match = (timer == val_q);

  // capture event selection by mode and prescale count
  always_comb
  begin
    cap_ev = 1'b0;
    pre_d = pre_q;
    case (mode)
      `ECCP_MODE_CAP_FALL: cap_ev = fall;
      `ECCP_MODE_CAP_RISE: cap_ev = rise;
      `ECCP_MODE_CAP_4TH, `ECCP_MODE_CAP_16TH:
      begin
        if (rise)
          pre_d = pre_q + 4'h1;
        cap_ev = rise && (mode == `ECCP_MODE_CAP_4TH ? pre_q[1:0] == 2'h3 : pre_q == 4'hf);
      end
      default: pre_d = 4'h0;
    endcase
  end

  // register writes, captures, compare actions and flags
  always_comb
  begin
    ctrl_d = ctrl_q;
    val_d = val_q;
    duty_d = duty_q;
    period_d = period_q;
    dead_d = dead_q;
    mask_d = mask_q;
    shut_auto_d = shut_auto_q;
    stat_d = stat_q;
    pin_d = pin_q;
    trig_d = 1'b0;
    cap_d = cap_in;
    if (rd && addr == `ECCP_OFF_STAT)
      stat_d = 2'b00;
    if (wr)
      case (addr)
        `ECCP_OFF_CTRL: ctrl_d = eccp_pkg::eccp_ctrl_t'(wdata);
        `ECCP_OFF_VAL_LO: val_d[7:0] = wdata;
        `ECCP_OFF_VAL_HI: val_d[15:8] = wdata;
        `ECCP_OFF_DUTY: duty_d = wdata;
        `ECCP_OFF_MASK: mask_d = wdata[1:0];
        `ECCP_OFF_DEAD: dead_d = wdata;
        `ECCP_OFF_SHUT: shut_auto_d = wdata[0];
        `ECCP_OFF_PERIOD: period_d = wdata;
        default: ;
      endcase
    if (cap_ev)
    begin
      val_d = timer;
      stat_d[`ECCP_ST_MATCH] = 1'b1;
    end
    if (match && mode[3:2] != 2'b01 && !pwm_mode && mode != `ECCP_MODE_OFF)
    begin
      stat_d[`ECCP_ST_MATCH] = 1'b1;
      case (mode)
        `ECCP_MODE_TOGGLE: pin_d = !pin_q;
        `ECCP_MODE_CMP_SET: pin_d = 1'b1;
        `ECCP_MODE_CMP_CLR: pin_d = 1'b0;
        `ECCP_MODE_CMP_TRIG: trig_d = 1'b1;
        default: ;
      endcase
    end
    if (fault)
      stat_d[`ECCP_ST_FAULT] = 1'b1;
    // off state clears the pin latch
    if (mode == `ECCP_MODE_OFF)
      pin_d = 1'b0;
  end

  // pwm counter and fault shutdown state
  always_comb
  begin
    pcnt_d = pcnt_q + 10'h1;
    if (!pwm_mode || pcnt_q == {period_q, 2'b11})
      pcnt_d = 10'h0;
    st_d = st_q;
    case (st_q)
      eccp_pkg::ECCP_RUN:
        if (fault && pwm_mode)
          st_d = eccp_pkg::ECCP_SHUT;
      eccp_pkg::ECCP_SHUT:
        // restart when fault clears and auto restart set, at period end
        if (!fault && shut_auto_q && pcnt_d == 10'h0)
          st_d = eccp_pkg::ECCP_RUN;
        else if (!pwm_mode)
          st_d = eccp_pkg::ECCP_RUN;
      default: st_d = eccp_pkg::ECCP_RUN;
    endcase
  end

  assign mod = pwm_mode && (pcnt_q < {duty_q, ctrl_q.duty_low_bits});
  assign mod_n_raw = pwm_mode && !mod;

  // dead band on the complementary half-bridge pair
  eccp_dead #(.W(DEAD_W)) u_dead_p (
    .clk(clk),
    .rst(rst),
    .lvl(mod),
    .delay(dead_q[DEAD_W-1:0]),
    .dly_lvl(dly_p)
  );
  eccp_dead #(.W(DEAD_W)) u_dead_n (
    .clk(clk),
    .rst(rst),
    .lvl(mod_n_raw),
    .delay(dead_q[DEAD_W-1:0]),
    .dly_lvl(dly_n)
  );

  // output steering, active levels then polarity
  always_comb
  begin
    act = '0;
    oe = '0;
    if (pwm_mode)
    begin
      oe = 4'hf;
      case (ctrl_q.bridge_output_config)
        `ECCP_CFG_SINGLE:
        begin
          act.pwm_out_a = mod;
          oe = 4'h8;
        end
        `ECCP_CFG_FWD:
        begin
          act.pwm_out_a = 1'b1;
          act.pwm_out_d = mod;
        end
        `ECCP_CFG_HALF:
        begin
          act.pwm_out_a = dly_p;
          act.pwm_out_b = dly_n;
          oe = 4'hc;
        end
        `ECCP_CFG_REV:
        begin
          act.pwm_out_b = mod;
          act.pwm_out_c = 1'b1;
        end
        default: ;
      endcase
      if (st_q == eccp_pkg::ECCP_SHUT)
        act = '0;
    end
    else if (mode == `ECCP_MODE_TOGGLE || mode == `ECCP_MODE_CMP_SET
             || mode == `ECCP_MODE_CMP_CLR)
    begin
      // only output A used outside PWM; soft modes leave pin to port
      act.pwm_out_a = pin_q;
      oe.pwm_out_a = 1'b1;
    end
    // polarity: bit0 sets B/D low, bit1 sets A/C low
    lvl = act;
    if (pwm_mode)
    begin
      lvl.pwm_out_a = act.pwm_out_a ^ mode[1];
      lvl.pwm_out_c = act.pwm_out_c ^ mode[1];
      lvl.pwm_out_b = act.pwm_out_b ^ mode[0];
      lvl.pwm_out_d = act.pwm_out_d ^ mode[0];
    end
  end

  // read mux, registered one cycle later
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd)
      case (addr)
        `ECCP_OFF_CTRL: rdata_d = ctrl_q;
        `ECCP_OFF_VAL_LO: rdata_d = val_q[7:0];
        `ECCP_OFF_VAL_HI: rdata_d = val_q[15:8];
        `ECCP_OFF_DUTY: rdata_d = duty_q;
        `ECCP_OFF_STAT: rdata_d = {6'h00, stat_q};
        `ECCP_OFF_MASK: rdata_d = {6'h00, mask_q};
        `ECCP_OFF_DEAD: rdata_d = dead_q;
        `ECCP_OFF_SHUT: rdata_d = {6'h00, st_q == eccp_pkg::ECCP_SHUT, shut_auto_q};
        `ECCP_OFF_PERIOD: rdata_d = period_q;
        default: rdata_d = 8'h00;
      endcase
  end

  // state registers; mode 0000 clears internal state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `ECCP_CTRL_RESET;
      val_q <= 16'h0000;
      duty_q <= 8'h00;
      period_q <= 8'hff;
      dead_q <= 8'h00;
      mask_q <= 2'h0;
      shut_auto_q <= 1'b0;
      stat_q <= 2'h0;
      st_q <= eccp_pkg::ECCP_RUN;
      rdata_q <= 8'h00;
      cap_q <= 1'b0;
      pin_q <= 1'b0;
      trig_q <= 1'b0;
      pre_q <= 4'h0;
      pcnt_q <= 10'h000;
      pwm_out <= '0;
      pwm_oe <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      val_q <= val_d;
      duty_q <= duty_d;
      period_q <= period_d;
      dead_q <= dead_d;
      mask_q <= mask_d;
      shut_auto_q <= shut_auto_d;
      stat_q <= stat_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      cap_q <= cap_d;
      pin_q <= pin_d;
      trig_q <= trig_d;
      pre_q <= pre_d;
      pcnt_q <= pcnt_d;
      pwm_out <= lvl;
      pwm_oe <= oe;
    end
  end

  assign rdata = rdata_q;
  assign adc_trigger = trig_q;
  assign irq = |(stat_q & mask_q);

  off_pins_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_OFF) ##1 (mode == `ECCP_MODE_OFF) |-> pwm_oe == '0)
    else $error("pins driven while off");
  // toggle mode flips the latch on match
  toggle_pin_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_TOGGLE && match) |=> pin_q != $past(pin_q))
    else $error("toggle missed on match");
  rise_cap_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_CAP_RISE && rise) |=> val_q == $past(timer))
    else $error("rising capture lost");
  // fourth edge capture needs prescale wrap
  fourth_cap_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_CAP_4TH && rise && pre_q[1:0] != 2'h3 && !wr) |=> val_q == $past(val_q))
    else $error("early capture in four edge mode");
  // software interrupt mode leaves pin to port
  soft_pin_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_CMP_SW) ##1 (mode == `ECCP_MODE_CMP_SW) |-> !pwm_oe.pwm_out_a)
    else $error("pin driven in soft compare mode");
  // B to D are port pins outside PWM
  port_pins_a: assert property (@(posedge clk) disable iff (rst)
    !$past(pwm_mode) |-> !pwm_oe.pwm_out_b && !pwm_oe.pwm_out_c && !pwm_oe.pwm_out_d)
    else $error("B to D driven outside pwm");
  // reverse bridge holds A and D at their inactive level, for any polarity
  rev_bridge_a: assert property (@(posedge clk) disable iff (rst)
    (pwm_mode && ctrl_q.bridge_output_config == `ECCP_CFG_REV)
    |=> pwm_out.pwm_out_a == $past(mode[1]) && pwm_out.pwm_out_d == $past(mode[0]))
    else $error("reverse bridge A or D active");
  // one trigger pulse, then low again unless another match follows
  sequence trig_once_s;
    adc_trigger ##1 (!adc_trigger || match);
  endsequence
  // trigger follows a match in trigger mode
  trig_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (mode == `ECCP_MODE_CMP_TRIG && match) |=> trig_once_s)
    else $error("trigger pulse missing");
  fault_shut_a: assert property (@(posedge clk) disable iff (rst)
    (fault && pwm_mode && st_q == eccp_pkg::ECCP_RUN) |=> st_q == eccp_pkg::ECCP_SHUT)
    else $error("fault did not shut down");
endmodule

// ==== eccp_unit_tb.sv ====
`timescale 1ns/1ps
`include "eccp_map.svh"
module eccp_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] timer;
  logic cap_in;
  logic cap_run = 1'b0;
  logic fault = 1'b0;
  eccp_pkg::eccp_outs_t pwm_out;
  eccp_pkg::eccp_outs_t pwm_oe;
  logic adc_trigger;
  logic irq;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] r1;
  always #25 clk = ~clk;
  eccp_unit u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer(timer), .cap_in(cap_in), .fault(fault), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .adc_trigger(adc_trigger), .irq(irq));
  eccp_far u_far (.clk(clk), .rst(rst), .cap_run(cap_run), .timer(timer), .cap_in(cap_in));
  // hang guard: the whole run needs under 1500 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle write; a free edge before each so strobes never collide
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read; data only stand in the following cycle
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // align to timer phase 10 so reads keep a fixed distance to captures
  task automatic sync();
    @(posedge clk);
    #1;
    for (int i = 0; i < 64 && timer[4:0] !== 5'h0a; i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // register reset values and an unmapped offset
  task automatic t_reset();
    rreg(`ECCP_OFF_CTRL, v);
    chk(v, `ECCP_CTRL_RESET);
    chk({4'h0, pwm_oe}, 8'h00);
    wreg(4'hf, 8'h5a);
    rreg(4'hf, v);
    chk(v, 8'h00);
  endtask
  // compare modes: match 40 counts ahead, watch pin, trigger and flag
  task automatic t_cmp(input logic [3:0] m, input logic [7:0] msk, input logic [3:0] oe,
    input int trg);
    logic [15:0] t;
    logic a0;
    int flips;
    int trigs;
    flips = 0;
    trigs = 0;
    wreg(`ECCP_OFF_CTRL, 8'h00);
    rreg(`ECCP_OFF_STAT, v);
    t = timer + 16'd40;
    wreg(`ECCP_OFF_VAL_LO, t[7:0]);
    wreg(`ECCP_OFF_VAL_HI, t[15:8]);
    wreg(`ECCP_OFF_MASK, msk);
    wreg(`ECCP_OFF_CTRL, {4'h0, m});
    @(posedge clk);
    #1 a0 = pwm_out.pwm_out_a;
    chk({4'h0, pwm_oe}, {4'h0, oe});
    repeat (60)
    begin
      @(posedge clk);
      #1 flips += (pwm_out.pwm_out_a !== a0);
      a0 = pwm_out.pwm_out_a;
      trigs += (adc_trigger !== 1'b0);
    end
    if (oe != 4'h0)
      chk(8'(flips), 8'h01);
    chk(8'(trigs), 8'(trg));
    chk({7'h0, irq}, msk);
    rreg(`ECCP_OFF_STAT, v);
    chk(v, 8'h01);
  endtask
  // edge selection and prescale, judged by distances between captures
  task automatic t_cap();
    int nz;
    logic [7:0] sum;
    nz = 0;
    sum = 8'h00;
    @(posedge clk);
    cap_run <= 1'b1;
    wreg(`ECCP_OFF_CTRL, {4'h0, `ECCP_MODE_CAP_RISE});
    repeat (80) @(posedge clk);
    sync();
    rreg(`ECCP_OFF_VAL_LO, r1);
    rreg(`ECCP_OFF_STAT, v);
    chk(v, 8'h01);
    sync();
    rreg(`ECCP_OFF_VAL_LO, v);
    chk(v - r1, 8'h20);
    wreg(`ECCP_OFF_CTRL, {4'h0, `ECCP_MODE_CAP_FALL});
    repeat (40) @(posedge clk);
    sync();
    rreg(`ECCP_OFF_VAL_LO, v);
    chk((v - r1) & 8'h1f, 8'h10);
    wreg(`ECCP_OFF_CTRL, {4'h0, `ECCP_MODE_CAP_4TH});
    repeat (300) @(posedge clk);
    sync();
    rreg(`ECCP_OFF_VAL_LO, r1);
    // four gaps of 32 counts hold exactly one capture of 128
    repeat (4)
    begin
      sync();
      rreg(`ECCP_OFF_VAL_LO, v);
      nz += (v != r1);
      sum += v - r1;
      r1 = v;
    end
    chk(8'(nz), 8'h01);
    chk(sum, 8'h80);
    @(posedge clk);
    cap_run <= 1'b0;
  endtask
  // reverse bridge, active low, 16-count period, duty 4 then 5
  task automatic t_pwm(input logic [7:0] ctl, input int duty);
    int lo_b;
    int bad;
    lo_b = 0;
    bad = 0;
    wreg(`ECCP_OFF_PERIOD, 8'h03);
    wreg(`ECCP_OFF_DUTY, 8'h01);
    wreg(`ECCP_OFF_CTRL, ctl);
    repeat (40) @(posedge clk);
    #1 chk({4'h0, pwm_oe}, 8'h0f);
    repeat (16)
    begin
      @(posedge clk);
      #1 lo_b += (pwm_out.pwm_out_b === 1'b0);
      bad += (pwm_out.pwm_out_a !== 1'b1) + (pwm_out.pwm_out_c !== 1'b0);
      bad += (pwm_out.pwm_out_d !== 1'b1);
    end
    chk(8'(bad), 8'h00);
    chk(8'(lo_b), 8'(duty));
  endtask
  // fault shuts down, auto restart releases once fault is gone
  task automatic t_fault();
    wreg(`ECCP_OFF_MASK, 8'h02);
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h01);
    // active-low outputs all rest high while shut down
    chk({4'h0, pwm_out}, 8'h0f);
    rreg(`ECCP_OFF_SHUT, v);
    chk(v & 8'h02, 8'h02);
    @(posedge clk);
    fault <= 1'b0;
    wreg(`ECCP_OFF_SHUT, 8'h01);
    repeat (40) @(posedge clk);
    rreg(`ECCP_OFF_SHUT, v);
    chk(v & 8'h02, 8'h00);
    wreg(`ECCP_OFF_CTRL, 8'h00);
    @(posedge clk);
    #1 chk({4'h0, pwm_oe}, 8'h00);
  endtask
  // half bridge with dead band: 16-count period, duty 8, two dead counts
  task automatic t_half();
    int hi_a;
    int hi_b;
    int both;
    hi_a = 0;
    hi_b = 0;
    both = 0;
    wreg(`ECCP_OFF_DEAD, 8'h02);
    wreg(`ECCP_OFF_DUTY, 8'h02);
    wreg(`ECCP_OFF_CTRL, 8'h8c);
    repeat (40) @(posedge clk);
    #1 chk({4'h0, pwm_oe}, 8'h0c);
    repeat (16)
    begin
      @(posedge clk);
      #1 hi_a += (pwm_out.pwm_out_a === 1'b1);
      hi_b += (pwm_out.pwm_out_b === 1'b1);
      both += (pwm_out.pwm_out_a !== 1'b0) && (pwm_out.pwm_out_b !== 1'b0);
    end
    // each side loses its two dead counts out of eight, and never overlaps the other
    chk(8'(hi_a), 8'h06);
    chk(8'(hi_b), 8'h06);
    chk(8'(both), 8'h00);
  endtask
  // verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_cmp(`ECCP_MODE_TOGGLE, 8'h01, 4'h8, 0);
    t_cmp(`ECCP_MODE_CMP_SET, 8'h01, 4'h8, 0);
    t_cmp(`ECCP_MODE_CMP_SW, 8'h00, 4'h0, 0);
    t_cmp(`ECCP_MODE_CMP_TRIG, 8'h01, 4'h0, 1);
    t_cap();
    t_pwm(8'hcf, 4);
    t_pwm(8'hdf, 5);
    t_fault();
    t_half();
    complete_run();
  end
endmodule
